// ### cmcs_pkg.sv
// Purpose: Shared constants for the control mode and configuration select block
// Assumes: Serial frames are 32 bits, MSB first, with a 12-bit header
// Notes: Register offsets are the 4-bit serial addresses
package cmcs_pkg;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [3:0] CMCS_ADDR_CAL = 4'h0;
    localparam logic [3:0] CMCS_ADDR_OUT_FMT = 4'h1;
    localparam logic [3:0] CMCS_ADDR_I_OFS = 4'h2;
    localparam logic [3:0] CMCS_ADDR_I_RNG = 4'h3;
    localparam logic [3:0] CMCS_ADDR_EXT_CFG = 4'h9;
    localparam logic [3:0] CMCS_ADDR_Q_OFS = 4'hA;
    localparam logic [3:0] CMCS_ADDR_Q_RNG = 4'hB;
    localparam logic [3:0] CMCS_ADDR_PH_FINE = 4'hE;
    localparam logic [3:0] CMCS_ADDR_PH_CM = 4'hF;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CMCS_CAL_BIT = 15;
    localparam int CMCS_SECOND_CLK_N_BIT = 13;
    localparam int CMCS_DCP_BIT = 11;
    localparam int CMCS_DDR_N_BIT = 10;
    localparam int CMCS_SWING_BIT = 9;
    localparam int CMCS_OED_BIT = 8;
    localparam int CMCS_TPO_BIT = 15;
    localparam int CMCS_RTD_BIT = 14;
    localparam int CMCS_DES_BIT = 13;
    localparam int CMCS_DES_Q_BIT = 12;
    localparam int CMCS_ADJ_MSB = 15;
    localparam int CMCS_ADJ_LSB = 7;
    localparam int CMCS_FINE_LSB = 8;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] CMCS_OUT_FMT_RST = 16'hB2FF;
    localparam logic [15:0] CMCS_OFS_RST = 16'h007F;
    localparam logic [15:0] CMCS_RNG_RST = 16'h807F;
    localparam logic [15:0] CMCS_EXT_CFG_RST = 16'h03FF;
    localparam logic [15:0] CMCS_PH_FINE_RST = 16'h00FF;
    localparam logic [15:0] CMCS_PH_CM_RST = 16'h007F;
    localparam logic [8:0] CMCS_FSR_MID_CODE = 9'h100;

    // ----------------------------------------
    // Serial frame and timing
    // ----------------------------------------
    localparam logic [11:0] CMCS_FRAME_HEADER = 12'h001;
    localparam logic [5:0] CMCS_FRAME_LAST_BIT = 6'h1F;
    localparam logic [2:0] CMCS_MODE_SETTLE_CYCLES = 3'h4;

    // ----------------------------------------
    // Synchronised pin vector layout
    // ----------------------------------------
    localparam int CMCS_PIN_COUNT = 12;
    localparam int CMCS_P_MODE = 0;
    localparam int CMCS_P_MODE_FLT = 1;
    localparam int CMCS_P_DES = 2;
    localparam int CMCS_P_DES_FLT = 3;
    localparam int CMCS_P_RNG = 4;
    localparam int CMCS_P_RNG_FLT = 5;
    localparam int CMCS_P_EDGE = 6;
    localparam int CMCS_P_EDGE_FLT = 7;
    localparam int CMCS_P_SWING = 8;
    localparam int CMCS_P_SCS_N = 9;
    localparam int CMCS_P_SCLK = 10;
    localparam int CMCS_P_SDATA = 11;

endpackage : cmcs_pkg

// ### cmcs_serial_rx.sv
// Purpose: Collect 32-bit serial register frames into write strobes
// Assumes: Inputs are already synchronised to core_clk
// Notes: Back-to-back frames need no chip select release
`timescale 1ns/1ns
module cmcs_serial_rx (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic scs_n,
    input wire logic sclk_rise,
    input wire logic sdata,
    output logic wr_stb,
    output logic [3:0] wr_addr,
    output logic [15:0] wr_data
);

    // ----------------------------------------
    // Shift and count
    // ----------------------------------------
    logic [31:0] shift_reg;
    logic [31:0] shift_next;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic take_bit;
    logic frame_done;
    logic header_ok;

    assign take_bit = enable & ~scs_n & sclk_rise;
    assign shift_next = {shift_reg[30:0], sdata};
    assign frame_done = take_bit & (cnt_reg == cmcs_pkg::CMCS_FRAME_LAST_BIT);
    // A bad header drops the frame; the count still realigns
    assign header_ok = (shift_next[31:20] == cmcs_pkg::CMCS_FRAME_HEADER);
    assign cnt_next = frame_done ? 6'h00 : (take_bit ? cnt_reg + 6'h01 : cnt_reg);

    always_ff @(posedge core_clk) begin
        if (!rst_n || !enable || scs_n) begin
            cnt_reg <= 6'h00;
            shift_reg <= 32'h0000_0000;
        end else begin
            cnt_reg <= cnt_next;
            shift_reg <= take_bit ? shift_next : shift_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_stb <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 16'h0000;
        end else begin
            wr_stb <= frame_done & header_ok;
            if (frame_done) begin
                wr_addr <= shift_next[19:16];
                wr_data <= shift_next[15:0];
            end
        end
    end

endmodule : cmcs_serial_rx

// ### cmcs_control_select.sv
// Purpose: Choose pin-driven or register-driven control of converter features
// Assumes: Pin float detection is done by board or pad logic outside
// Notes: Mode is sampled once after reset and then held
//
// Notes on behaviour
// RULE_01: Mode-select pin low selects extended register control; high selects standard pin control.
// RULE_02: Mode pin floating, dual-edge pin floating or high, range pin floating: extended.
// RULE_03: Host fixes the control mode before operation and never switches it live.
// RULE_04: Double rate from output-edge pin float in standard, config bit 10 in extended.
// RULE_05: Double-rate clock phase is zero in standard, config bit 11 in extended.
// RULE_06: Single-rate data edge follows output-edge pin in standard, config bit 8 extended.
// RULE_07: Output swing follows swing pin in standard, config bit 9 in extended.
// RULE_08: Calibration delay short with delay pin low, longer with it high.
// RULE_09: Range from pin for both channels in standard; registers 3h, Bh in extended.
// RULE_10: No offset adjust in standard; registers 2h and Ah bits 15:7 in extended.
// RULE_11: Dual-edge sampling from pin float in standard, bit 13 of 9h extended.
// RULE_12: Dual-edge uses I input in standard; I or Q selectable in extended.
// RULE_13: Test pattern bit 15 of 9h drives outputs; none in standard mode.
// RULE_14: Trim-disable bit keeps data clocks running continuously; none in standard mode.
// RULE_15: Extended double rate: bit 8 high non-demultiplexed, low one-to-two demultiplexed.
// RULE_16: Second-clock bit 13 low turns out-of-range pair into second clock copy.
// RULE_17: Sample clock phase adjust only extended, from Fh bits 15:7, Eh 15:8.
// RULE_18: Reset defaults: double rate, zero phase, high swing, short delay, mid range.
// RULE_19: Reset defaults: no dual-edge, no pattern, trim on, demux, no second clock.
// RULE_20: Register contents are ignored entirely in standard control mode.
// RULE_21: Bit 8 picks data edge in single rate and demux mode in double rate.
// RULE_22: Mode pins are sampled once after reset and the choice is held.
`timescale 1ns/1ns
module cmcs_control_select (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic mode_pin_level,
    input wire logic mode_pin_float,
    input wire logic des_delay_pin_level,
    input wire logic des_delay_pin_float,
    input wire logic range_pin_level,
    input wire logic range_pin_float,
    input wire logic output_edge_pin,
    input wire logic output_edge_pin_float,
    input wire logic output_swing_pin,
    input wire logic serial_cs_n,
    input wire logic serial_clk,
    input wire logic serial_data,
    output logic mode_valid,
    output logic extended_mode,
    output logic ddr_enable,
    output logic ddr_clock_phase_sel,
    output logic sdr_edge_rising,
    output logic demux_one_to_two,
    output logic output_swing_sel,
    output logic cal_delay_long,
    output logic fsr_reduced,
    output logic [8:0] fsr_i_code,
    output logic [8:0] fsr_q_code,
    output logic [8:0] offset_i_code,
    output logic [8:0] offset_q_code,
    output logic des_enable,
    output logic des_q_input_sel,
    output logic test_pattern_en,
    output logic trim_off_clock_keep,
    output logic second_clock_out_n,
    output logic [8:0] phase_coarse_mid,
    output logic [7:0] phase_fine,
    output logic cal_request
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [cmcs_pkg::CMCS_PIN_COUNT-1:0] pin_raw;
    logic [cmcs_pkg::CMCS_PIN_COUNT-1:0] pin_meta_reg;
    logic [cmcs_pkg::CMCS_PIN_COUNT-1:0] pin_sync_reg;

    logic sclk_prev_reg;
    logic sclk_rise;

    assign pin_raw = {serial_data, serial_clk, serial_cs_n, output_swing_pin,
                      output_edge_pin_float, output_edge_pin, range_pin_float, range_pin_level,
                      des_delay_pin_float, des_delay_pin_level, mode_pin_float, mode_pin_level};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            sclk_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            sclk_prev_reg <= pin_sync_reg[cmcs_pkg::CMCS_P_SCLK];
        end
    end

    assign sclk_rise = pin_sync_reg[cmcs_pkg::CMCS_P_SCLK] & ~sclk_prev_reg;

    // ----------------------------------------
    // Mode capture
    // ----------------------------------------
    logic [2:0] settle_reg;
    logic ext_mode_reg;
    logic mode_valid_reg;

    logic mode_low;
    logic alt_select;
    logic ext_decision;
    logic settled;

    assign mode_low = ~pin_sync_reg[cmcs_pkg::CMCS_P_MODE_FLT] & ~pin_sync_reg[cmcs_pkg::CMCS_P_MODE];
    assign alt_select = pin_sync_reg[cmcs_pkg::CMCS_P_MODE_FLT]
                        & (pin_sync_reg[cmcs_pkg::CMCS_P_DES_FLT] | pin_sync_reg[cmcs_pkg::CMCS_P_DES])
                        & pin_sync_reg[cmcs_pkg::CMCS_P_RNG_FLT];

    assign ext_decision = mode_low | alt_select; // RULE_01 RULE_02
    assign settled = (settle_reg == cmcs_pkg::CMCS_MODE_SETTLE_CYCLES);

    // Sampled once so a live pin change cannot flip control mid-run
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            settle_reg <= 3'h0;
            ext_mode_reg <= 1'b0;
            mode_valid_reg <= 1'b0;
        end else if (!mode_valid_reg) begin
            settle_reg <= settled ? settle_reg : settle_reg + 3'h1;
            ext_mode_reg <= settled ? ext_decision : 1'b0; // RULE_22 RULE_03
            mode_valid_reg <= settled;
        end
    end

    // ----------------------------------------
    // Serial register writes
    // ----------------------------------------
    logic wr_stb;
    logic [3:0] wr_addr;
    logic [15:0] wr_data;

    // The serial port only listens in extended mode
    cmcs_serial_rx u_serial_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(ext_mode_reg),
        .scs_n(pin_sync_reg[cmcs_pkg::CMCS_P_SCS_N]),
        .sclk_rise(sclk_rise),
        .sdata(pin_sync_reg[cmcs_pkg::CMCS_P_SDATA]),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    logic [15:0] out_fmt_reg;

    logic [15:0] i_ofs_reg;
    logic [15:0] i_rng_reg;

    logic [15:0] ext_cfg_reg;

    logic [15:0] q_ofs_reg;
    logic [15:0] q_rng_reg;

    logic [15:0] ph_fine_reg;
    logic [15:0] ph_cm_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_fmt_reg <= cmcs_pkg::CMCS_OUT_FMT_RST; // RULE_18 RULE_19
            i_ofs_reg <= cmcs_pkg::CMCS_OFS_RST;
            i_rng_reg <= cmcs_pkg::CMCS_RNG_RST;
            ext_cfg_reg <= cmcs_pkg::CMCS_EXT_CFG_RST; // RULE_19
            q_ofs_reg <= cmcs_pkg::CMCS_OFS_RST;
            q_rng_reg <= cmcs_pkg::CMCS_RNG_RST;
            ph_fine_reg <= cmcs_pkg::CMCS_PH_FINE_RST;
            ph_cm_reg <= cmcs_pkg::CMCS_PH_CM_RST;
        end else if (wr_stb) begin
            case (wr_addr)
                cmcs_pkg::CMCS_ADDR_OUT_FMT: out_fmt_reg <= wr_data;
                cmcs_pkg::CMCS_ADDR_I_OFS: i_ofs_reg <= wr_data;
                cmcs_pkg::CMCS_ADDR_I_RNG: i_rng_reg <= wr_data;
                cmcs_pkg::CMCS_ADDR_EXT_CFG: ext_cfg_reg <= wr_data;
                cmcs_pkg::CMCS_ADDR_Q_OFS: q_ofs_reg <= wr_data;
                cmcs_pkg::CMCS_ADDR_Q_RNG: q_rng_reg <= wr_data;
                cmcs_pkg::CMCS_ADDR_PH_FINE: ph_fine_reg <= wr_data;
                cmcs_pkg::CMCS_ADDR_PH_CM: ph_cm_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Feature selection
    // ----------------------------------------
    logic ext;

    logic ddr_sel;
    logic phase_sel;
    logic edge_sel;
    logic demux_sel;
    logic swing_sel;

    logic delay_sel;
    logic reduced_sel;
    logic [8:0] fsr_i_sel;
    logic [8:0] fsr_q_sel;

    logic [8:0] ofs_i_sel;
    logic [8:0] ofs_q_sel;

    logic des_sel;
    logic des_q_sel;
    logic tpo_sel;
    logic rtd_sel;
    logic sd_n_sel;

    logic [8:0] cm_sel;
    logic [7:0] fine_sel;

    logic cal_sel;

    // Standard mode gates every register field off
    assign ext = ext_mode_reg; // RULE_20

    assign ddr_sel = ext ? ~out_fmt_reg[cmcs_pkg::CMCS_DDR_N_BIT]
                         : pin_sync_reg[cmcs_pkg::CMCS_P_EDGE_FLT]; // RULE_04
    assign phase_sel = ext & ddr_sel & out_fmt_reg[cmcs_pkg::CMCS_DCP_BIT]; // RULE_05
    assign edge_sel = ~ddr_sel & (ext ? out_fmt_reg[cmcs_pkg::CMCS_OED_BIT]
                                      : pin_sync_reg[cmcs_pkg::CMCS_P_EDGE]); // RULE_06 RULE_21
    assign demux_sel = ~(ext & ddr_sel & out_fmt_reg[cmcs_pkg::CMCS_OED_BIT]); // RULE_15 RULE_21

    assign swing_sel = ext ? out_fmt_reg[cmcs_pkg::CMCS_SWING_BIT]
                           : pin_sync_reg[cmcs_pkg::CMCS_P_SWING]; // RULE_07

    // Floating means dual-edge, so only a driven high asks for the long delay
    assign delay_sel = pin_sync_reg[cmcs_pkg::CMCS_P_DES] & ~pin_sync_reg[cmcs_pkg::CMCS_P_DES_FLT]; // RULE_08
    assign reduced_sel = ~ext & ~pin_sync_reg[cmcs_pkg::CMCS_P_RNG]; // RULE_09
    assign fsr_i_sel = ext ? i_rng_reg[cmcs_pkg::CMCS_ADJ_MSB:cmcs_pkg::CMCS_ADJ_LSB]
                           : cmcs_pkg::CMCS_FSR_MID_CODE; // RULE_09
    assign fsr_q_sel = ext ? q_rng_reg[cmcs_pkg::CMCS_ADJ_MSB:cmcs_pkg::CMCS_ADJ_LSB]
                           : cmcs_pkg::CMCS_FSR_MID_CODE; // RULE_09

    assign ofs_i_sel = ext ? i_ofs_reg[cmcs_pkg::CMCS_ADJ_MSB:cmcs_pkg::CMCS_ADJ_LSB] : 9'h000; // RULE_10
    assign ofs_q_sel = ext ? q_ofs_reg[cmcs_pkg::CMCS_ADJ_MSB:cmcs_pkg::CMCS_ADJ_LSB] : 9'h000; // RULE_10

    assign des_sel = ext ? ext_cfg_reg[cmcs_pkg::CMCS_DES_BIT]
                         : pin_sync_reg[cmcs_pkg::CMCS_P_DES_FLT]; // RULE_11
    assign des_q_sel = ext & des_sel & ext_cfg_reg[cmcs_pkg::CMCS_DES_Q_BIT]; // RULE_12

    assign tpo_sel = ext & ext_cfg_reg[cmcs_pkg::CMCS_TPO_BIT]; // RULE_13
    assign rtd_sel = ext & ext_cfg_reg[cmcs_pkg::CMCS_RTD_BIT]; // RULE_14
    assign sd_n_sel = ~ext | out_fmt_reg[cmcs_pkg::CMCS_SECOND_CLK_N_BIT]; // RULE_16

    assign cm_sel = ext ? ph_cm_reg[cmcs_pkg::CMCS_ADJ_MSB:cmcs_pkg::CMCS_ADJ_LSB] : 9'h000; // RULE_17
    assign fine_sel = ext ? ph_fine_reg[cmcs_pkg::CMCS_ADJ_MSB:cmcs_pkg::CMCS_FINE_LSB] : 8'h00; // RULE_17

    assign cal_sel = wr_stb & (wr_addr == cmcs_pkg::CMCS_ADDR_CAL) & wr_data[cmcs_pkg::CMCS_CAL_BIT];

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_valid <= 1'b0;
            extended_mode <= 1'b0;
            ddr_enable <= 1'b0;
            ddr_clock_phase_sel <= 1'b0;
            sdr_edge_rising <= 1'b0;
            demux_one_to_two <= 1'b1;
            output_swing_sel <= 1'b1;
            cal_delay_long <= 1'b0;
            fsr_reduced <= 1'b0;
            fsr_i_code <= cmcs_pkg::CMCS_FSR_MID_CODE;
            fsr_q_code <= cmcs_pkg::CMCS_FSR_MID_CODE;
            offset_i_code <= 9'h000;
            offset_q_code <= 9'h000;
            des_enable <= 1'b0;
            des_q_input_sel <= 1'b0;
            test_pattern_en <= 1'b0;
            trim_off_clock_keep <= 1'b0;
            second_clock_out_n <= 1'b1;
            phase_coarse_mid <= 9'h000;
            phase_fine <= 8'h00;
            cal_request <= 1'b0;
        end else begin
            mode_valid <= mode_valid_reg;
            extended_mode <= ext;
            ddr_enable <= ddr_sel;
            ddr_clock_phase_sel <= phase_sel;
            sdr_edge_rising <= edge_sel;
            demux_one_to_two <= demux_sel;
            output_swing_sel <= swing_sel;
            cal_delay_long <= delay_sel;
            fsr_reduced <= reduced_sel;
            fsr_i_code <= fsr_i_sel;
            fsr_q_code <= fsr_q_sel;
            offset_i_code <= ofs_i_sel;
            offset_q_code <= ofs_q_sel;
            des_enable <= des_sel;
            des_q_input_sel <= des_q_sel;
            test_pattern_en <= tpo_sel;
            trim_off_clock_keep <= rtd_sel;
            second_clock_out_n <= sd_n_sel;
            phase_coarse_mid <= cm_sel;
            phase_fine <= fine_sel;
            cal_request <= cal_sel;
        end
    end

endmodule : cmcs_control_select

// ### cmcs_control_select_assertions.sv
// Purpose: Port-level checks of the control select block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to the design from tb_top
`timescale 1ns/1ns
module cmcs_control_select_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic mode_pin_level,
    input wire logic mode_pin_float,
    input wire logic des_delay_pin_level,
    input wire logic des_delay_pin_float,
    input wire logic range_pin_float,
    input wire logic output_swing_pin,
    input wire logic mode_valid,
    input wire logic extended_mode,
    input wire logic ddr_enable,
    input wire logic ddr_clock_phase_sel,
    input wire logic sdr_edge_rising,
    input wire logic demux_one_to_two,
    input wire logic output_swing_sel,
    input wire logic [8:0] fsr_i_code,
    input wire logic [8:0] fsr_q_code,
    input wire logic [8:0] offset_i_code,
    input wire logic [8:0] offset_q_code,
    input wire logic des_q_input_sel,
    input wire logic test_pattern_en,
    input wire logic trim_off_clock_keep,
    input wire logic second_clock_out_n,
    input wire logic [8:0] phase_coarse_mid,
    input wire logic [7:0] phase_fine
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic ext_pick = (!mode_pin_float && !mode_pin_level)
        || (mode_pin_float && (des_delay_pin_float || des_delay_pin_level) && range_pin_float);
    wire logic std_on = mode_valid && !extended_mode;
    // Five cycles cover two sync stages and the output flop
    sequence s_swing_steady;
        (std_on && $stable(output_swing_pin)) [*5];
    endsequence
    property p_mode_pick; $rose(mode_valid) |-> extended_mode == ext_pick; endproperty
    property p_mode_hold; mode_valid |=> $stable(extended_mode); endproperty
    property p_valid_hold; mode_valid |=> mode_valid; endproperty
    property p_std_fixed;
        !extended_mode |-> !ddr_clock_phase_sel && !test_pattern_en && !trim_off_clock_keep && second_clock_out_n;
    endproperty
    property p_std_adjust;
        !extended_mode |-> fsr_i_code == 9'h100 && fsr_q_code == 9'h100 && offset_i_code == 9'h000
            && offset_q_code == 9'h000 && phase_coarse_mid == 9'h000 && phase_fine == 8'h00;
    endproperty
    property p_std_des_i; !extended_mode |-> !des_q_input_sel; endproperty
    property p_ddr_edge; ddr_enable |-> !sdr_edge_rising; endproperty
    property p_sdr_demux; !ddr_enable |-> demux_one_to_two && !ddr_clock_phase_sel; endproperty
    property p_std_swing; s_swing_steady |-> output_swing_sel == output_swing_pin; endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("mode choice wrong");
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
    a_valid_hold: assert property (p_valid_hold) else $error("mode valid dropped");
    a_std_fixed: assert property (p_std_fixed) else $error("standard extras set");
    a_std_adjust: assert property (p_std_adjust) else $error("standard codes wrong");
    a_std_des_i: assert property (p_std_des_i) else $error("standard picks Q");
    a_ddr_edge: assert property (p_ddr_edge) else $error("edge set in double rate");
    a_sdr_demux: assert property (p_sdr_demux) else $error("single rate demux");
    a_std_swing: assert property (p_std_swing) else $error("swing not from pin");
endmodule : cmcs_control_select_assertions

// ### cmcs_host_model.sv
// Purpose: Host side serial writer for the control select block
// Assumes: Serial clock phases of four core cycles
// Notes: Serial clock stands low and data toggles between frames
`timescale 1ns/1ns
module cmcs_host_model (
    input wire logic core_clk,
    output logic serial_cs_n,
    output logic serial_clk,
    output logic serial_data
);
    initial begin
        serial_cs_n = 1'b1;
        serial_clk = 1'b0;
        serial_data = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : hold
    // ----------------------------------------
    // Frame writer, MSB first
    // ----------------------------------------
    task automatic send_frame(input logic [31:0] frame);
        for (int i = 31; i >= 0; i--) begin
            serial_cs_n = 1'b0;
            serial_data = frame[i];
            serial_clk = 1'b0;
            hold(4);
            serial_clk = 1'b1;
            hold(4);
        end
        serial_clk = 1'b0;
        hold(4);
        serial_cs_n = 1'b1;
        // Released line must not look like a held value
        serial_data = ~serial_data;
    endtask : send_frame
endmodule : cmcs_host_model

// ### tb_top.sv
// Purpose: Self-checking bench for the control select block
// Assumes: Mode pins change only under reset, except for live changes of des_delay_pin_float and mode_pin_level in the tests
// Notes: Writes go through the host model
`timescale 1ns/1ns
module tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode_pin_level = 1'b1, mode_pin_float = 1'b0, des_delay_pin_level = 1'b0, des_delay_pin_float = 1'b0;
    logic range_pin_level = 1'b1, range_pin_float = 1'b0, output_edge_pin = 1'b0, output_edge_pin_float = 1'b0;
    logic output_swing_pin = 1'b1;
    wire logic serial_cs_n, serial_clk, serial_data;
    logic mode_valid, extended_mode, ddr_enable, ddr_clock_phase_sel, sdr_edge_rising, demux_one_to_two;
    logic output_swing_sel, cal_delay_long, fsr_reduced, des_enable, des_q_input_sel, test_pattern_en;
    logic trim_off_clock_keep, second_clock_out_n, cal_request;
    logic [8:0] fsr_i_code, fsr_q_code, offset_i_code, offset_q_code, phase_coarse_mid;
    logic [7:0] phase_fine;
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] cal_seen = 8'h00;
    wire logic [5:0] fmt = {ddr_enable, ddr_clock_phase_sel, sdr_edge_rising, demux_one_to_two,
        output_swing_sel, second_clock_out_n};
    localparam logic [6:0] MODE_TAB [6] = '{7'h05, 7'h50, 7'h33, 7'h2B, 7'h22, 7'h34};
    localparam logic [15:0] FMT_TAB [6] = '{16'h8000, 16'hAB00, 16'h8F00, 16'h8400, 16'hA200, 16'h8900};
    localparam logic [15:0] EXT_TAB [5] = '{16'h8000, 16'h4000, 16'h2000, 16'h3000, 16'h0000};
    localparam logic [3:0] ADJ_A [6] = '{4'h2, 4'hA, 4'h3, 4'hB, 4'hF, 4'hE};
    localparam logic [15:0] ADJ_V [6] = '{16'hFF80, 16'h0080, 16'h0000, 16'hFFFF, 16'h5580, 16'hA5FF};
    always #5 core_clk = ~core_clk;
    cmcs_control_select cmcs_control_select_inst (.*);
    cmcs_host_model cmcs_host_model_inst (.*);
    always @(posedge core_clk) if (rst_n) cal_seen <= cal_seen + 8'(cal_request);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic check(input string name, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic do_reset(input logic [5:0] p);
        rst_n = 1'b0;
        {mode_pin_level, mode_pin_float, des_delay_pin_level, des_delay_pin_float, range_pin_level,
            range_pin_float} = p;
        tick(8);
        rst_n = 1'b1;
        tick(8);
    endtask : do_reset
    task automatic wr(input logic [3:0] a, input logic [15:0] v, input logic [11:0] h = 12'h001);
        cmcs_host_model_inst.send_frame({h, a, v});
        tick(8);
    endtask : wr
    function automatic logic [5:0] exp_fmt(input logic ext, input logic [15:0] v);
        logic ddr;
        ddr = ext ? !v[10] : output_edge_pin_float;
        return {ddr, ext & ddr & v[11], !ddr & (ext ? v[8] : output_edge_pin), (ext & ddr) ? !v[8] : 1'b1,
            ext ? v[9] : output_swing_pin, ext ? v[13] : 1'b1};
    endfunction : exp_fmt
    function automatic logic [8:0] adj_out(input logic [3:0] a);
        case (a)
            4'h2: return offset_i_code;
            4'hA: return offset_q_code;
            4'h3: return fsr_i_code;
            4'hB: return fsr_q_code;
            4'hF: return phase_coarse_mid;
            default: return {1'b0, phase_fine};
        endcase
    endfunction : adj_out
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 6; i++) begin
            do_reset(MODE_TAB[i][6:1]);
            check("mode_valid", 32'(mode_valid), 32'h1);
            check("extended_mode", 32'(extended_mode), 32'(MODE_TAB[i][0]));
        end
        do_reset(6'h28);
        check("cal_range", {cal_delay_long, fsr_reduced}, 32'h3);
        for (int j = 0; j < 8; j++) begin
            {output_edge_pin_float, output_edge_pin, output_swing_pin} = 3'(j);
            tick(6);
            check("std_format", 32'(fmt), 32'(exp_fmt(1'b0, 16'h0000)));
        end
        wr(4'h9, 16'hF000);
        wr(4'h1, 16'h8400);
        wr(4'h2, 16'hFF80);
        wr(4'h0, 16'h8000);
        check("std_ignore", {fmt, test_pattern_en, trim_off_clock_keep, offset_i_code}, {exp_fmt(1'b0, 16'h0), 11'h0});
        des_delay_pin_float = 1'b1;
        tick(6);
        check("std_des", {des_enable, des_q_input_sel, cal_delay_long}, 32'h4);
        // Illegal live mode change; capture must hold
        mode_pin_level = 1'b0;
        tick(6);
        check("mode_held", 32'(extended_mode), 32'h0);
        output_swing_pin = 1'b0;
        output_edge_pin_float = 1'b0;
        do_reset(6'h02);
        check("def_format", 32'(fmt), 32'h27);
        check("def_ext", {test_pattern_en, trim_off_clock_keep, des_enable, des_q_input_sel}, 32'h0);
        check("def_fsr", {fsr_i_code, fsr_q_code, cal_delay_long, fsr_reduced}, {9'h100, 9'h100, 2'h0});
        check("def_ofs", {offset_i_code, offset_q_code}, 32'h0);
        check("def_phase", {phase_coarse_mid, phase_fine}, 32'h0);
        foreach (FMT_TAB[k]) begin
            wr(4'h1, FMT_TAB[k]);
            check("ext_format", 32'(fmt), 32'(exp_fmt(1'b1, FMT_TAB[k])));
        end
        foreach (EXT_TAB[k]) begin
            wr(4'h9, EXT_TAB[k]);
            check("ext_cfg", {test_pattern_en, trim_off_clock_keep, des_enable, des_q_input_sel}, 32'(EXT_TAB[k][15:12]));
        end
        foreach (ADJ_A[k]) begin
            wr(ADJ_A[k], ADJ_V[k]);
            check("adjust", 32'(adj_out(ADJ_A[k])), (ADJ_A[k] == 4'hE) ? 32'(ADJ_V[k][15:8]) : 32'(ADJ_V[k][15:7]));
        end
        wr(4'h2, 16'h0000, 12'h003);
        wr(4'h4, 16'h0000);
        wr(4'h0, 16'h8000);
        check("refused", 32'(offset_i_code), 32'h1FF);
        check("cal_request", 32'(cal_seen), 32'h1);
        results();
    end
    initial begin
        #500000;
        err_count++;
        results();
    end
endmodule : tb_top
bind cmcs_control_select cmcs_control_select_assertions cmcs_control_select_assertions_inst (.*);
